/* hw/ccc_map.svh */
/*
 holds the timing-free constants and defaults of the counter channel core.
 assumes it is included by its bare name from the core.
*/
// What this block does
// RULE1 - main direction up: count from load value to end minus one, wrap to load
// RULE2 - main direction down: count from start value to one, wrap to start
// RULE3 - no main direction selected means no range limit; this is the default
// RULE4 - endless counting mode ignores the main direction limit
// RULE5 - cancel gate mode, the default, restarts from load value on gate reopen
// RULE6 - stop gate mode holds count while closed and resumes on reopen
// RULE7 - start value defaults to 2147483647
// RULE8 - end value accepts two up to 2147483647
// RULE9 - count always compared against comparison value, default 0, range-bounded
// RULE10 - hysteresis 0 to 255, default 0; values 0 and 1 disable it
// RULE11 - pulse/direction by default, plus rotary single, double, quadruple
// RULE12 - with hardware gating on, channel 3 needs software and hardware gate open
// RULE13 - with hardware gating off, channel 3 is gated by software gate alone
// RULE14 - optional inversion of direction input, off by default
// RULE15 - channel mode is deactivated, endless, once or periodic
// RULE16 - rotary modes give one, two, four counts per period; A/B phase sets direction
`ifndef CCC_MAP_SVH
`define CCC_MAP_SVH
`define CCC_START_DEFAULT 32'h7FFF_FFFF
`define CCC_END_MIN 32'h0000_0002
`define CCC_END_MAX 32'h7FFF_FFFF
`define CCC_CMP_DEFAULT 32'h0000_0000
`define CCC_HYST_DEFAULT 8'h00
`define CCC_HYST_MIN_ON 8'h02
`define CCC_HARDWARE_GATE_INPUT_CHANNEL 2'h3
`endif

/* hw/ccc_pkg.sv */
/*
 holds the mode enumerations of the counter channel core.
 assumes ccc_map.svh is on the include path.
*/
package ccc_pkg;
  typedef enum logic [1:0] {
    ccc_mode_off, ccc_mode_endless, ccc_mode_once, ccc_mode_periodic
  } ccc_mode_e;
  typedef enum logic [1:0] {
    ccc_dir_none, ccc_dir_up, ccc_dir_down
  } ccc_main_dir_e;
  typedef enum logic [1:0] {
    ccc_eval_pulse_dir, ccc_eval_single, ccc_eval_double, ccc_eval_quad
  } ccc_eval_e;
  typedef enum logic {
    ccc_gate_cancel, ccc_gate_stop
  } ccc_gate_e;
endpackage

/* hw/ccc_core.sv */
/*
 holds the counter channel core: input evaluation, gating, range limit and
 comparator with hysteresis. assumes encoder inputs synchronous to clock
 and filtered outside; configuration ports held stable by the owner.
*/
`include "ccc_map.svh"
module ccc_core #(
  parameter logic [1:0] channel = 2'h0,
  parameter int width = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // encoder inputs
  input wire logic track_a,
  input wire logic track_b,
  // gates
  input wire logic software_gate,
  input wire logic hardware_gate_input,
  // configuration
  input wire ccc_pkg::ccc_mode_e mode,
  input wire ccc_pkg::ccc_main_dir_e main_dir,
  input wire ccc_pkg::ccc_eval_e eval,
  input wire ccc_pkg::ccc_gate_e gate_mode,
  input wire logic hardware_gate_input_enable,
  input wire logic dir_invert,
  input wire logic [width-1:0] load_value,
  input wire logic [width-1:0] start_value,
  input wire logic [width-1:0] end_value,
  input wire logic [width-1:0] cmp_value,
  input wire logic [7:0] hysteresis,
  input wire logic cmp_le_mode,
  // status
  output logic [width-1:0] count,
  output logic gate_open,
  output logic cmp_hit,
  output logic cfg_error
);
  typedef struct packed {
    logic [width-1:0] count;
    logic a_d;
    logic b_d;
    logic gate_d;
    logic cmp;
    logic err;
  } ccc_state_s;

  ccc_state_s st;
  ccc_state_s next_st;
  logic gate;
  logic dir_in;
  logic step;
  logic down;
  logic a_rise;
  logic a_fall;
  logic b_edge;
  logic a_edge;
  logic signed [width:0] diff;
  logic signed [width:0] band;

  always_comb begin
    // only channel 3 owns a hardware gate; elsewhere the pin is ignored
    if (channel == `CCC_HARDWARE_GATE_INPUT_CHANNEL && hardware_gate_input_enable) begin
      gate = software_gate & hardware_gate_input; // RULE12
    end else begin
      gate = software_gate; // RULE13
    end
    dir_in = track_b ^ dir_invert; // RULE14
    a_rise = track_a & ~st.a_d;
    a_fall = ~track_a & st.a_d;
    a_edge = track_a ^ st.a_d;
    b_edge = track_b ^ st.b_d;
    step = 1'b0;
    down = 1'b0;
    case (eval) // RULE11
      ccc_pkg::ccc_eval_pulse_dir: begin
        step = a_rise;
        down = dir_in;
      end
      ccc_pkg::ccc_eval_single: begin
        step = a_rise; // RULE16
        down = track_b ^ dir_invert;
      end
      ccc_pkg::ccc_eval_double: begin
        step = a_edge; // RULE16
        down = (track_a ^ track_b) ^ ~dir_invert;
      end
      ccc_pkg::ccc_eval_quad: begin
        // both tracks moving at once is a lost step; it is dropped
        step = a_edge ^ b_edge; // RULE16
        if (a_edge) begin
          down = (track_a ^ track_b) ^ ~dir_invert;
        end else begin
          down = (track_a ^ track_b) ^ dir_invert;
        end
      end
      default: begin
        step = 1'b0;
        down = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.a_d = track_a;
    next_st.b_d = track_b;
    next_st.gate_d = gate;
    next_st.err = (main_dir == ccc_pkg::ccc_dir_up) &&
      (end_value < `CCC_END_MIN || end_value > `CCC_END_MAX); // RULE8
    if (mode == ccc_pkg::ccc_mode_off) begin
      next_st.count = '0; // RULE15
    end else if (gate && !st.gate_d && gate_mode == ccc_pkg::ccc_gate_cancel)
    begin
      next_st.count = load_value; // RULE5
    end else if (gate && step) begin
      // stop mode simply freezes the count while the gate is closed
      if (mode == ccc_pkg::ccc_mode_endless ||
          main_dir == ccc_pkg::ccc_dir_none) begin
        if (down) begin
          next_st.count = st.count - 1'b1; // RULE3 RULE4
        end else begin
          next_st.count = st.count + 1'b1; // RULE3 RULE4
        end
      end else if (main_dir == ccc_pkg::ccc_dir_up) begin
        if (!down && st.count >= end_value - 1'b1) begin
          next_st.count = load_value; // RULE1
        end else if (down) begin
          next_st.count = st.count - 1'b1;
        end else begin
          next_st.count = st.count + 1'b1; // RULE1
        end
      end else begin
        if (down && st.count <= {{(width-1){1'b0}}, 1'b1}) begin
          next_st.count = start_value; // RULE2
        end else if (down) begin
          next_st.count = st.count - 1'b1; // RULE2
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
    end // RULE6
    // hysteresis: output sets on reaching the comparison value but only clears once count leaves a band below (above with cmp_le_mode) the
    // comparison value, trading response near the threshold for stability
    diff = $signed({next_st.count[width-1], next_st.count}) -
      $signed({cmp_value[width-1], cmp_value});
    band = $signed({{(width-7){1'b0}}, hysteresis});
    if (hysteresis < `CCC_HYST_MIN_ON) begin
      if (cmp_le_mode) begin
        next_st.cmp = (diff <= 0); // RULE9 RULE10
      end else begin
        next_st.cmp = (diff >= 0); // RULE9 RULE10
      end
    end else if (cmp_le_mode) begin
      if (diff <= 0) begin
        next_st.cmp = 1'b1;
      end else if (diff >= band) begin
        next_st.cmp = 1'b0; // RULE10
      end
    end else begin
      if (diff >= 0) begin
        next_st.cmp = 1'b1;
      end else if (diff <= -band) begin
        next_st.cmp = 1'b0; // RULE10
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign gate_open = st.gate_d;
  assign cmp_hit = st.cmp;
  assign cfg_error = st.err;
endmodule // ccc_core

/* test/ccc_chk.sv */
/* port checker of the counter channel core.
 assumes the bind below and 32-bit counts. */
module ccc_chk (
  // watched ports
  input wire logic clock, srst, track_a, track_b, dir_invert,
  input wire logic software_gate, hardware_gate_input, hardware_gate_input_enable,
  input wire ccc_pkg::ccc_mode_e mode,
  input wire ccc_pkg::ccc_main_dir_e main_dir,
  input wire ccc_pkg::ccc_eval_e eval,
  input wire ccc_pkg::ccc_gate_e gate_mode,
  input wire logic [31:0] load_value, start_value, end_value, count,
  input wire logic gate_open, cfg_error
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // no gate edge in flight, so a step is a plain step
  sequence run;
    mode > 2'h1 && !eval && gate_open && software_gate && !hardware_gate_input_enable;
  endsequence
  sequence up_s;
    run ##0 $rose(track_a) && track_b == dir_invert && main_dir == 2'h1;
  endsequence
  sequence dn_s;
    run ##0 $rose(track_a) && track_b != dir_invert && main_dir == 2'h2;
  endsequence
  AST_UP: assert property (up_s ##0 count == end_value - 1
    |=> count == load_value) else $error("up wrap missed");
  AST_DN: assert property (dn_s ##0 count == 1
    |=> count == start_value) else $error("down wrap missed");
  AST_HOLD: assert property (!software_gate && mode != 2'h0
    |=> $stable(count)) else $error("count moved, gate shut");
  AST_LOAD: assert property (software_gate && !gate_open
    && !gate_mode && !hardware_gate_input_enable && mode != 2'h0
    |=> count == load_value) else $error("no reload");
  AST_HWG: assert property (hardware_gate_input_enable && !hardware_gate_input
    |=> !gate_open) else $error("hardware gate ignored");
  AST_SWG: assert property (!hardware_gate_input_enable && software_gate
    |=> gate_open) else $error("gate not open");
  AST_CFG: assert property (main_dir == 2'h1
    && (end_value < 2 || end_value[31]) |=> cfg_error) else $error("bad end");
  AST_OFF: assert property (mode == 2'h0 |=> count == 0)
    else $error("off but counting");
endmodule // ccc_chk
bind ccc_core ccc_chk u_chk (.clock, .srst, .track_a, .track_b, .dir_invert,
  .software_gate, .hardware_gate_input, .hardware_gate_input_enable, .mode, .main_dir,
  .eval, .gate_mode, .load_value, .start_value, .end_value, .count,
  .gate_open, .cfg_error);

/* test/ccc_enc.sv */
/* encoder and pulse source for the core.
 assumes calls away from reset. */
module ccc_enc (
  input wire logic clock,
  output logic a = 1'b0,
  output logic b = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // direction settles an edge ahead of the pulse
  task pulse(input logic dn);
    @(posedge clock) b <= dn;
    @(posedge clock) a <= 1'b1;
    @(posedge clock) a <= 1'b0;
  endtask
  // a leads b going up; one track moves per edge
  task quad(input logic dn);
    logic [7:0] s;
    s = dn ? 8'h78 : 8'hb4;
    for (int i = 3; i >= 0; i--) @(posedge clock) {a, b} <= s[2*i+:2];
    @(posedge clock);
  endtask
endmodule // ccc_enc

/* test/test_counter_channel_core.sv */
/* bench for the core as channel 3.
 assumes the encoder model drives the tracks. */
module test_counter_channel_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, srst = 1'b1, software_gate = 1'b0, dir_invert = 1'b0;
  logic hardware_gate_input = 1'b0, hardware_gate_input_enable = 1'b0;
  logic [31:0] end_value = 32'h0000_000a;
  logic [31:0] load_value = 32'h0000_0005, cmp_value = 32'h0000_0007;
  logic [7:0] hysteresis = 8'h00;
  logic cmp_le_mode = 1'b0;
  ccc_pkg::ccc_mode_e mode = ccc_pkg::ccc_mode_endless;
  ccc_pkg::ccc_main_dir_e main_dir = ccc_pkg::ccc_dir_none;
  ccc_pkg::ccc_eval_e eval = ccc_pkg::ccc_eval_pulse_dir;
  ccc_pkg::ccc_gate_e gate_mode = ccc_pkg::ccc_gate_cancel;
  logic track_a, track_b, gate_open, cmp_hit, cfg_error;
  logic [31:0] count;
  int bad_count = 0, compares = 0;
  always #20 clock = ~clock;
  ccc_enc u_enc (.clock, .a(track_a), .b(track_b));
  ccc_core #(.channel(2'h3)) u_dut (.clock, .srst, .track_a, .track_b,
    .software_gate, .hardware_gate_input, .mode, .main_dir, .eval,
    .gate_mode, .hardware_gate_input_enable, .dir_invert, .load_value,
    .start_value(32'h0000_0003), .end_value, .cmp_value,
    .hysteresis, .cmp_le_mode, .count, .gate_open, .cmp_hit,
    .cfg_error);
  task chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task cc(input logic [31:0] e);
    #1 chk(count, e);
  endtask
  task test_done;
    $display("bad %0d of %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    software_gate <= 1'b1;
    @(posedge clock);
    cc(8'h05);
    repeat (3) u_enc.pulse(1'b0);
    cc(8'h08);
    chk(cmp_hit, 1'b1);
    @(posedge clock) main_dir <= ccc_pkg::ccc_dir_up;
    repeat (2) u_enc.pulse(1'b0);
    cc(8'h0a);
    @(posedge clock) mode <= ccc_pkg::ccc_mode_periodic;
    u_enc.pulse(1'b1);
    u_enc.pulse(1'b0);
    cc(8'h05);
    chk(cmp_hit, 1'b0);
    @(posedge clock) dir_invert <= 1'b1;
    u_enc.pulse(1'b1);
    cc(8'h06);
    @(posedge clock);
    dir_invert <= 1'b0;
    gate_mode <= ccc_pkg::ccc_gate_stop;
    software_gate <= 1'b0;
    repeat (2) u_enc.pulse(1'b0);
    @(posedge clock) software_gate <= 1'b1;
    u_enc.pulse(1'b0);
    cc(8'h07);
    @(posedge clock) main_dir <= ccc_pkg::ccc_dir_down;
    repeat (7) u_enc.pulse(1'b1);
    cc(8'h03);
    @(posedge clock);
    gate_mode <= ccc_pkg::ccc_gate_cancel;
    main_dir <= ccc_pkg::ccc_dir_none;
    hardware_gate_input_enable <= 1'b1;
    u_enc.pulse(1'b0);
    #1 chk(gate_open, 1'b0);
    @(posedge clock) hardware_gate_input <= 1'b1;
    u_enc.pulse(1'b0);
    cc(8'h06);
    for (int e = 1; e < 4; e++) begin
      @(posedge clock) eval <= ccc_pkg::ccc_eval_e'(e);
      u_enc.quad(1'b0);
    end
    u_enc.quad(1'b1);
    cc(8'h09);
    @(posedge clock);
    cmp_value <= 32'h0000_000b;
    hysteresis <= 8'h03;
    @(posedge clock);
    #1 chk(cmp_hit, 1'b1);
    u_enc.quad(1'b1);
    #1 chk(cmp_hit, 1'b0);
    u_enc.quad(1'b0);
    #1 chk(cmp_hit, 1'b0);
    @(posedge clock) cmp_le_mode <= 1'b1;
    @(posedge clock);
    #1 chk(cmp_hit, 1'b1);
    @(posedge clock);
    main_dir <= ccc_pkg::ccc_dir_up;
    end_value <= 32'h0000_0001;
    @(posedge clock) end_value <= 32'h0000_0002;
    #1 chk(cfg_error, 1'b1);
    @(posedge clock) mode <= ccc_pkg::ccc_mode_off;
    #1 chk(cfg_error, 1'b0);
    @(posedge clock);
    cc(8'h00);
    test_done;
  end
endmodule // test_counter_channel_core
